// [core/mgab_buzzer.sv]
// square wave generator for the buzzer alternate function
`timescale 1ns/1ps
`include "mgab_defines.svh"
module mgab_buzzer (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        enable,
    input  wire logic [15:0] half_period,
    output logic             wave
);
    logic [15:0] cnt_q;
    logic        wave_q;
    wire         at_end = (cnt_q >= half_period);
    // half_period zero means silent, so an idle pattern keeps the line low
    wire         run    = enable && (half_period != `MGAB_BUZZ_RST);

    // counter toggles the line each half period
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= 16'h0000;
            wave_q <= 1'b0;
        end else if (clk_en) begin
            if (!run) begin
                cnt_q  <= 16'h0000;
                wave_q <= 1'b0;
            end else if (at_end) begin
                cnt_q  <= 16'h0000;
                wave_q <= ~wave_q;
            end else begin
                cnt_q  <= cnt_q + 16'h0001;
            end
        end
    end
    assign wave = wave_q;
endmodule

// [core/mgab_gpio.sv]
// seven pin gpio port with alarm and buzzer functions, wishbone registers
`timescale 1ns/1ps
`include "mgab_defines.svh"
module mgab_gpio (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        clk_en,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    input  wire logic [6:0]  pin_in,
    output logic      [6:0]  pin_out,
    output logic      [6:0]  pin_oe,
    input  wire logic        alarm_event,
    input  wire logic        cam_variant,
    input  wire logic [6:0]  cam_out,
    input  wire logic [6:0]  cam_oe,
    output logic      [6:0]  cam_in,
    output logic             irq
);
    ////////////////////////////////////////////////////////////////////////
    // reset synchroniser
    logic rst_m_q;
    logic rst_n_q;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_m_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_n_q <= rst_m_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    mgab_pkg::mgab_req_t req;
    logic                ack_q;
    logic                err_q;
    logic [31:0]         rdat_q;
    assign req.adr = wb_adr_i;
    assign req.we  = wb_we_i;
    assign req.dat = wb_dat_i;

    wire acc     = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
    wire wr      = acc && req.we && wb_sel_i[0];
    wire hit_mode = (req.adr == `MGAB_ADR_MODE);
    wire hit_out  = (req.adr == `MGAB_ADR_OUT);
    wire hit_in   = (req.adr == `MGAB_ADR_IN);
    wire hit_alm  = (req.adr == `MGAB_ADR_ALARM);
    wire hit_buz  = (req.adr == `MGAB_ADR_BUZZ);
    wire hit_cam  = (req.adr == `MGAB_ADR_CAM);
    wire hit_ist  = (req.adr == `MGAB_ADR_IRQ_STAT);
    wire hit_ien  = (req.adr == `MGAB_ADR_IRQ_EN);
    wire hit_icl  = (req.adr == `MGAB_ADR_IRQ_CLR);
    wire mapped   = hit_mode | hit_out | hit_in | hit_alm | hit_buz
                  | hit_cam | hit_ist | hit_ien | hit_icl;
    // mode register spans two byte lanes, so both must be enabled
    wire wr_mode  = wr && hit_mode && wb_sel_i[1];
    wire wr_out   = wr && hit_out;
    wire wr_alm   = wr && hit_alm;
    wire wr_buz   = wr && hit_buz && wb_sel_i[1];
    wire wr_cam   = wr && hit_cam;
    wire wr_ien   = wr && hit_ien;
    wire wr_icl   = wr && hit_icl;

    ////////////////////////////////////////////////////////////////////////
    // per-pin mode filter
    logic [13:0] mode_q;
    logic [13:0] mode_d;
    logic [6:0]  reject;
    logic [20:0] allow;
    assign allow = 21'(`MGAB_ALLOW_TBL);

    genvar gi;
    generate
        for (gi = 0; gi < `MGAB_NPINS; gi++) begin : g_mode
            wire [1:0] req_m = req.dat[2*gi +: 2];
            // code 3 is never legal, other codes checked against the table
            wire       ok    = (req_m != 2'(mgab_pkg::MGAB_MODE_RSV))
                             && allow[3*gi + int'(req_m)];
            assign reject[gi] = wr_mode && !ok;
            assign mode_d[2*gi +: 2] = (wr_mode && ok) ? req_m
                                     : mode_q[2*gi +: 2];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [6:0]  out_q;
    logic [6:0]  in_q;
    logic [6:0]  in_prev_q;
    logic        alarm_q;
    logic [15:0] buz_q;
    logic        cam_q;
    logic [2:0]  ist_q;
    logic [2:0]  ien_q;

    // reset state: pins are inputs, second pin is the only output pin
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mode_q <= `MGAB_MODE_RST;
            out_q  <= `MGAB_OUT_RST;
            buz_q  <= `MGAB_BUZZ_RST;
            cam_q  <= 1'b0;
            ien_q  <= 3'h0;
        end else if (clk_en) begin
            mode_q <= mode_d;
            if (wr_out) out_q <= req.dat[6:0];
            if (wr_buz) buz_q <= req.dat[15:0];
            if (wr_cam) cam_q <= req.dat[0];
            if (wr_ien) ien_q <= req.dat[2:0];
        end
    end

    // pin samples feed the input register and change detect
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            in_q      <= 7'h00;
            in_prev_q <= 7'h00;
        end else if (clk_en) begin
            in_q      <= pin_in;
            in_prev_q <= in_q;
        end
    end

    // alarm latch: set wins over the clearing write
    wire alarm_clr = wr_alm && req.dat[0];
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            alarm_q <= 1'b0;
        end else if (clk_en) begin
            if (alarm_event) alarm_q <= 1'b1;
            else if (alarm_clr) alarm_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drive
    wire buzz_wave;
    mgab_buzzer u_buzz (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n_q),
        .clk_en      (clk_en),
        .enable      (mode_q[13:12] == 2'(mgab_pkg::MGAB_MODE_ALT)),
        .half_period (buz_q),
        .wave        (buzz_wave)
    );

    mgab_pkg::mgab_pins_t drv;
    logic [6:0] in_mask;
    generate
        for (gi = 0; gi < `MGAB_NPINS; gi++) begin : g_pin
            wire [1:0] m     = mode_q[2*gi +: 2];
            wire       is_o  = (m == 2'(mgab_pkg::MGAB_MODE_OUT));
            wire       is_a  = (m == 2'(mgab_pkg::MGAB_MODE_ALT));
            wire       alt_v = (gi == 5) ? alarm_q
                             : (gi == 6) ? buzz_wave
                             : 1'b0;
            if (gi == 1) begin : g_oc
                // open collector: drive only the low level
                assign drv.dout[gi] = 1'b0;
                assign drv.oe[gi]   = is_o && !out_q[gi];
            end else begin : g_pp
                // push-pull, alternate value overrides user level
                assign drv.dout[gi] = is_a ? alt_v : out_q[gi];
                assign drv.oe[gi]   = is_o || is_a;
            end
            assign in_mask[gi] = (m == 2'(mgab_pkg::MGAB_MODE_IN));
        end
    endgenerate

    // camera takes pins two to seven when the variant has it enabled
    wire       cam_on   = cam_variant && cam_q;
    wire [6:0] cam_mask = cam_on ? 7'h7E : 7'h00;
    assign pin_out = (drv.dout & ~cam_mask) | (cam_out & cam_mask);
    assign pin_oe  = (drv.oe & ~cam_mask) | (cam_oe & cam_mask);
    assign cam_in  = pin_in & cam_mask;

    ////////////////////////////////////////////////////////////////////////
    // interrupts
    wire [2:0] ev;
    assign ev[`MGAB_IRQ_ALARM]  = alarm_event && !alarm_q;
    assign ev[`MGAB_IRQ_REJECT] = |reject;
    assign ev[`MGAB_IRQ_INCHG]  = |((in_q ^ in_prev_q) & in_mask);
    wire [2:0] icl = wr_icl ? req.dat[2:0] : 3'h0;
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ist_q <= 3'h0;
        end else if (clk_en) begin
            ist_q <= ev | (ist_q & ~icl); // set wins over clear
        end
    end
    assign irq = |(ist_q & ien_q);

    ////////////////////////////////////////////////////////////////////////
    // read mux and ack
    // output pins report the set level, never the pin
    wire [6:0] pin_rd = (in_q & in_mask) | (out_q & ~in_mask);
    wire [31:0] rd_mux =
          hit_mode ? {18'h0, mode_q}
        : hit_out  ? {25'h0, out_q}
        : hit_in   ? {25'h0, pin_rd}
        : hit_alm  ? {31'h0, alarm_q}
        : hit_buz  ? {16'h0, buz_q}
        : hit_cam  ? {31'h0, cam_on}
        : hit_ist  ? {29'h0, ist_q}
        : hit_ien  ? {29'h0, ien_q}
        : 32'h0000_0000;
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ack_q  <= 1'b0;
            err_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else if (clk_en) begin
            ack_q  <= acc && mapped;
            err_q  <= acc && !mapped;
            rdat_q <= rd_mux;
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;
    assign wb_dat_o = rdat_q;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    // mode limits per pin, refusals leave the field alone
    input_only_pin_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n_q)
        mode_q[1:0] == 2'h0)
        else $error("first pin left input mode");
    out_only_pin_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n_q)
        mode_q[3:2] == 2'h1)
        else $error("second pin left output mode");
    no_alt_mid_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n_q)
        mode_q[9:4] != 6'h2A && mode_q[5:4] != 2'h2 && mode_q[7:6] != 2'h2
        && mode_q[9:8] != 2'h2)
        else $error("alt on pins 3-5");
    no_rsv_mode_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n_q)
        mode_q[11:10] != 2'h3 && mode_q[13:12] != 2'h3)
        else $error("reserved mode stored");
    refuse_keeps_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n_q)
        clk_en && wr_mode && reject[2] |=> $stable(mode_q[5:4]))
        else $error("refused mode changed");
    reject_flag_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n_q)
        clk_en && |reject |=> ist_q[1])
        else $error("refusal not flagged");
    // pin drive per mode; camera ownership excluded where it takes over
    first_pin_free_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n_q)
        !pin_oe[0])
        else $error("first pin driven");
    open_coll_high_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n_q)
        pin_oe[1] && !cam_on |-> pin_out[1] == 1'b0)
        else $error("pin2 drove high");
    oc_pull_low_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n_q)
        !cam_on && !out_q[1] |-> pin_oe[1])
        else $error("pin2 not pulled low");
    oc_release_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n_q)
        !cam_on && out_q[1] |-> !pin_oe[1])
        else $error("pin2 not released");
    push_pull_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n_q)
        mode_q[5:4] == 2'h1 && !cam_on |-> pin_oe[2] && pin_out[2] == out_q[2])
        else $error("output pin not driven");
    in_released_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n_q)
        mode_q[5:4] == 2'h0 && !cam_on |-> !pin_oe[2])
        else $error("input pin driven");
    read_in_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n_q)
        clk_en && acc && !req.we && hit_in && mode_q[1:0] == 2'h0
        |=> wb_dat_o[0] == $past(in_q[0]))
        else $error("input read bad");
    read_out_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n_q)
        clk_en && acc && !req.we && hit_in && mode_q[7:6] == 2'h1
        |=> wb_dat_o[3] == $past(out_q[3]))
        else $error("read bad");
    alt_no_user_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n_q)
        clk_en && wr_out && mode_q[11:10] == 2'h2 && !cam_on
        && !alarm_event |=> $stable(pin_out[5]))
        else $error("user write moved alarm pin");
    // alarm latch and buzzer line
    alarm_rise_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n_q)
        clk_en && alarm_event |=> alarm_q)
        else $error("alarm not set");
    alarm_hold_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n_q)
        clk_en && alarm_q && !alarm_clr |=> alarm_q)
        else $error("alarm fell early");
    alarm_clear_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n_q)
        clk_en && alarm_clr && !alarm_event |=> !alarm_q)
        else $error("alarm not cleared");
    alarm_pin_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n_q)
        mode_q[11:10] == 2'h2 && !cam_on |-> pin_oe[5] && pin_out[5] == alarm_q)
        else $error("alarm pin wrong");
    buzz_pin_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n_q)
        mode_q[13:12] == 2'h2 && !cam_on |-> pin_oe[6] && pin_out[6] == buzz_wave)
        else $error("buzzer pin wrong");
    buzz_quiet_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n_q)
        clk_en && mode_q[13:12] != 2'h2 |=> !buzz_wave)
        else $error("buzzer runs outside alt mode");
    // camera sharing
    cam_route_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n_q)
        cam_on |-> pin_oe[6:1] == cam_oe[6:1]
        && pin_out[6:1] == cam_out[6:1])
        else $error("camera not routed");
    cam_blind_a: assert property (
        @(posedge ref_clk) disable iff (!rst_n_q)
        !cam_on |-> cam_in == 7'h00)
        else $error("camera sees pins while off");
endmodule

// [include/mgab_defines.svh]
// offsets, field positions, widths, reset values and allowed modes for the gpio port
`ifndef MGAB_DEFINES_SVH
`define MGAB_DEFINES_SVH
`define MGAB_ADR_MODE      8'h00
`define MGAB_ADR_OUT       8'h04
`define MGAB_ADR_IN        8'h08
`define MGAB_ADR_ALARM     8'h0C
`define MGAB_ADR_BUZZ      8'h10
`define MGAB_ADR_CAM       8'h14
`define MGAB_ADR_IRQ_STAT  8'h18
`define MGAB_ADR_IRQ_EN    8'h1C
`define MGAB_ADR_IRQ_CLR   8'h20
`define MGAB_NPINS         7
`define MGAB_MODE_W        14
`define MGAB_MODE_RST      14'h0004
`define MGAB_OUT_RST       7'h7F
`define MGAB_HALF_W        16
`define MGAB_BUZZ_RST      16'h0000
`define MGAB_IRQ_W         3
`define MGAB_IRQ_ALARM     0
`define MGAB_IRQ_REJECT    1
`define MGAB_IRQ_INCHG     2
// per-pin allowed modes, bit0 input, bit1 output, bit2 alternate
`define MGAB_ALLOW_TBL     21'o7733321
`endif

// [include/mgab_pkg.sv]
// types for the gpio port
package mgab_pkg;
    typedef enum logic [1:0] {
        MGAB_MODE_IN  = 2'h0,
        MGAB_MODE_OUT = 2'h1,
        MGAB_MODE_ALT = 2'h2,
        MGAB_MODE_RSV = 2'h3
    } mgab_mode_t;
    typedef struct packed {
        logic [6:0] dout;
        logic [6:0] oe;
    } mgab_pins_t;
    typedef struct packed {
        logic [7:0]  adr;
        logic        we;
        logic [31:0] dat;
    } mgab_req_t;
endpackage

// [tb/mgab_ext_dev.sv]
// model of the digital devices and camera wired to the gpio pins
`timescale 1ns/1ps
module mgab_ext_dev (
    input  wire logic       ref_clk,
    input  wire logic [6:0] pin_out,
    input  wire logic [6:0] pin_oe,
    input  wire logic [6:0] ext_val,
    input  wire logic [6:0] ext_drv,
    input  wire logic       cam_sel,
    output logic      [6:0] pin_in,
    output logic      [6:0] cam_out,
    output logic      [6:0] cam_oe
);
    logic [6:0] junk_q = 7'h55;
    // floating lines wander so a stale level never passes for a read
    always_ff @(posedge ref_clk) junk_q <= ~junk_q;
    // module wins, then the device; pin two floats up through its pull-up
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv & ext_val)
                  | (~pin_oe & ~ext_drv & (junk_q | 7'h02));
    // camera lets go of the shared pins unless it is selected
    assign cam_oe  = cam_sel ? 7'h7E : 7'h00;
    assign cam_out = cam_sel ? ext_val : junk_q;
endmodule

// [tb/module_gpio_with_alarm_buzzer_tb.sv]
// self-checking bench for the gpio port
`timescale 1ns/1ps
`include "mgab_defines.svh"
module module_gpio_with_alarm_buzzer_tb;
    logic        ref_clk = 0, nrst = 0, we = 0, cyc = 0, stb = 0;
    logic        alarm = 0, cam_v = 0, cam_sel = 0, ce = 1, e;
    logic [7:0]  adr = 0;
    logic [31:0] dat = 0, q;
    logic [6:0]  ext_val = 0, ext_drv = 0, pin_in, pin_out, pin_oe;
    logic [6:0]  cam_out, cam_oe, cam_in;
    logic [31:0] dat_o;
    logic        ack, err, irq;
    int          fails = 0, num_checks = 0, tick = 0, md[7], v, h, n;
    always #12.5 ref_clk = ~ref_clk;
    mgab_gpio uut (.ref_clk(ref_clk), .nrst(nrst), .clk_en(ce),
        .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_we_i(we),
        .wb_sel_i(4'hF), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
        .wb_err_o(err), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .alarm_event(alarm), .cam_variant(cam_v),
        .cam_out(cam_out), .cam_oe(cam_oe), .cam_in(cam_in), .irq(irq));
    mgab_ext_dev ext (.ref_clk(ref_clk), .pin_out(pin_out),
        .pin_oe(pin_oe), .ext_val(ext_val), .ext_drv(ext_drv),
        .cam_sel(cam_sel), .pin_in(pin_in), .cam_out(cam_out),
        .cam_oe(cam_oe));
    ////////////////////////////////////////////////////////////////////
    // one classic cycle, held until ack or err is seen at an edge
    task automatic wb(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
        int k;
        k = 0;
        adr <= a; we <= w; dat <= d; cyc <= 1; stb <= 1;
        do begin
            @(posedge ref_clk);
            k++;
        end while (ack !== 1'b1 && err !== 1'b1 && k < 20);
        q = dat_o;
        e = err;
        if (k >= 20) fails++;
        cyc <= 0; stb <= 0;
        @(posedge ref_clk);
    endtask
    task chk_reg(input logic [31:0] g, input logic [31:0] x);
        num_checks++;
        if (g !== x) begin
            fails++;
            $display("unexpected %0t reg %h want %h", $time, g, x);
        end
    endtask
    task chk_pin(input logic [6:0] g, input logic [6:0] x);
        num_checks++;
        if (g !== x) begin
            fails++;
            $display("unexpected %0t pins %h want %h", $time, g, x);
        end
    endtask
    task wrap_up;
        if (fails == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // which modes each pin accepts
    function automatic int ok(int p, int m);
        if (m == 3) return 0;
        if (p == 0) return m == 0;
        if (p == 1) return m == 1;
        if (p < 5) return m < 2;
        return 1;
    endfunction
    function automatic int mv();
        mv = 0;
        for (int i = 0; i < 7; i++) mv |= md[i] << (2 * i);
    endfunction
    // a hang still ends in the closing report
    always @(posedge ref_clk) begin
        tick++;
        if (tick == 20000) begin
            fails++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        v = $urandom(93);
        repeat (10) @(posedge ref_clk);
        nrst <= 1;
        repeat (3) @(posedge ref_clk);
        chk_pin(pin_oe, 7'h00);
        wb(`MGAB_ADR_OUT, 0, 0);
        chk_reg(q, 32'h7F);
        // every mode on every pin; refused ones leave the field alone
        md = '{0, 1, 0, 0, 0, 0, 0};
        for (int p = 0; p < 7; p++) for (int m = 0; m < 4; m++) begin
            wb(`MGAB_ADR_IRQ_CLR, 1, 7);
            v = md[p];
            md[p] = m;
            n = mv();
            if (ok(p, m) == 0) md[p] = v;
            wb(`MGAB_ADR_MODE, 1, n);
            wb(`MGAB_ADR_MODE, 0, 0);
            chk_reg(q & 32'h3FFF, mv());
            wb(`MGAB_ADR_IRQ_STAT, 0, 0);
            chk_reg(q & 2, ok(p, m) ? 0 : 2);
        end
        // outputs: push-pull except the open collector pin
        ext_drv <= 7'h01;
        wb(`MGAB_ADR_MODE, 1, 32'h1554);
        repeat (8) begin
            v = $urandom & 32'h7F;
            ext_val <= $urandom;
            wb(`MGAB_ADR_OUT, 1, v);
            chk_pin(pin_oe, {5'h1F, ~v[1], 1'b0});
            chk_pin(pin_in, {v[6:1], ext_val[0]});
            wb(`MGAB_ADR_IN, 0, 0);
            chk_reg(q & 32'h7F, {v[6:1], ext_val[0]});
        end
        // inputs: synchroniser delay allowed before reading
        ext_drv <= 7'h7D;
        wb(`MGAB_ADR_MODE, 1, 32'h0004);
        repeat (8) begin
            ext_val <= $urandom;
            repeat (3) @(posedge ref_clk);
            wb(`MGAB_ADR_IN, 0, 0);
            chk_reg(q & 32'h7F, {ext_val[6:2], v[1], ext_val[0]});
        end
        // alarm and buzzer alternate functions, interrupt masked first
        wb(`MGAB_ADR_MODE, 1, 32'h2804);
        h = 3 + $urandom % 8;
        wb(`MGAB_ADR_BUZZ, 1, h);
        wb(`MGAB_ADR_IRQ_EN, 1, 0);
        wb(`MGAB_ADR_IRQ_CLR, 1, 7);
        chk_pin(pin_oe & 7'h60, 7'h60);
        chk_pin(pin_out & 7'h20, 0);
        alarm <= 1;
        @(posedge ref_clk);
        alarm <= 0;
        repeat (3) @(posedge ref_clk);
        chk_pin(pin_out & 7'h20, 7'h20);
        chk_pin({6'h0, irq}, 0);
        wb(`MGAB_ADR_IRQ_EN, 1, 1);
        chk_pin({6'h0, irq}, 1);
        wb(`MGAB_ADR_OUT, 1, 0);
        chk_pin(pin_out & 7'h20, 7'h20);
        wb(`MGAB_ADR_ALARM, 0, 0);
        chk_reg(q & 1, 1);
        wb(`MGAB_ADR_ALARM, 1, 1);
        chk_pin(pin_out & 7'h20, 0);
        wb(`MGAB_ADR_IRQ_CLR, 1, 1);
        // clock enable low: an alarm pulse must leave no trace
        ce <= 0;
        alarm <= 1;
        @(posedge ref_clk);
        alarm <= 0;
        repeat (2) @(posedge ref_clk);
        ce <= 1;
        chk_pin(pin_out & 7'h20, 0);
        chk_pin({6'h0, irq}, 0);
        // half period: count edges between two toggles
        for (int r = 0; r < 2; r++) begin
            v = pin_out[6];
            n = 0;
            while (pin_out[6] === v[0] && n < 100) begin
                @(posedge ref_clk);
                n++;
            end
        end
        chk_reg(n, h + 1);
        // camera sharing only on the camera part
        wb(`MGAB_ADR_CAM, 1, 1);
        wb(`MGAB_ADR_CAM, 0, 0);
        chk_reg(q & 1, 0);
        cam_v <= 1;
        cam_sel <= 1;
        ext_val <= $urandom;
        wb(`MGAB_ADR_CAM, 1, 1);
        chk_pin(pin_out & 7'h7E, ext_val & 7'h7E);
        chk_pin(cam_in, ext_val & 7'h7E);
        wb(`MGAB_ADR_CAM, 1, 0);
        cam_sel <= 0;
        wb(8'h40, 0, 0);
        chk_reg({31'h0, e}, 1);
        wrap_up();
    end
endmodule
